//--- iasq_map.svh
// register offsets, field positions, reset values and timing counts for the adc sequencer
`ifndef IASQ_MAP_SVH
`define IASQ_MAP_SVH

// =============================================================
// register byte offsets
`define IASQ_OFF_CTRL      12'h000
`define IASQ_OFF_CFG       12'h004
`define IASQ_OFF_GAIN      12'h008
`define IASQ_OFF_STATUS    12'h00c
`define IASQ_OFF_RESULT    12'h010
`define IASQ_OFF_IRQ_STAT  12'h014
`define IASQ_OFF_IRQ_MASK  12'h018

// =============================================================
// control bits (write-only pulses)
`define IASQ_CTRL_START    0
`define IASQ_CTRL_DEFAULTS 1

// configuration field positions
`define IASQ_CFG_FS_LSB    0
`define IASQ_CFG_OSR_LSB   2
`define IASQ_CFG_NEL_LSB   5
`define IASQ_CFG_REF_LSB   7
`define IASQ_CFG_CONT      9

// gain register field positions
`define IASQ_GAIN_G_LSB    0
`define IASQ_GAIN_O_LSB    8

// =============================================================
// reset and default values
`define IASQ_DEF_FS        2'h0
`define IASQ_DEF_OSR       3'h2
`define IASQ_DEF_NEL       2'h1
`define IASQ_DEF_REF       2'h2
`define IASQ_DEF_GAIN      7'h0c
`define IASQ_DEF_OFFS      7'h40

// =============================================================
// timing: oscillator and clock frequencies in Hz and base divide to 500 kHz
`define IASQ_OSC_HZ        4000000
`define IASQ_CLK_HZ        100000000
`define IASQ_DIV_500K      ((`IASQ_CLK_HZ / `IASQ_OSC_HZ) * 8)
// extra cycles at start and end of a conversion
`define IASQ_SETTLE_CYC    4'h4

`endif

//--- iasq_mod_model.sv
// stand-in for the analog gain chain and modulator feeding the sequencer
`timescale 1ns/10ps
`default_nettype none

module iasq_mod_model (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_integrate,
    input  wire logic i_mod_reset,
    input  wire logic i_quantize,
    input  wire logic i_level,
    output logic      o_mod_bit
);
    logic filler_q;
    logic active;

    // =============================================================
    // outside a conversion the bit wanders so a stale value never passes as data
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            filler_q <= 1'b0;
        end else begin
            filler_q <= ~filler_q;
        end
    end

    // steady input level while the chain is busy, so offsets should cancel
    assign active    = i_integrate | i_mod_reset | i_quantize;
    assign o_mod_bit = active ? i_level : filler_q;
endmodule // iasq_mod_model

`default_nettype wire

//--- iasq_pkg.sv
// types used by the adc sequencer module iasq_seq
package iasq_pkg;

    typedef enum logic [1:0] {
        IASQ_REF_HIGH,
        IASQ_REF_LOW,
        IASQ_REF_TOGGLE,
        IASQ_REF_HALF
    } iasq_ref_mode_t;

    typedef struct packed {
        logic           cont;
        iasq_ref_mode_t ref_mode;
        logic [1:0]     nel_sel;
        logic [2:0]     osr_sel;
        logic [1:0]     fs_sel;
    } iasq_cfg_t;

    typedef struct packed {
        logic        neg;
        logic [5:0]  mag;
    } iasq_offset_t;

endpackage

//--- iasq_seq.sv
// incremental adc conversion sequencer with apb registers
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "iasq_map.svh"

module iasq_seq (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        i_mod_bit,
    output logic             o_integrate,
    output logic             o_mod_reset,
    output logic             o_offset_invert,
    output logic             o_ref_state,
    output logic             o_quantize,
    output logic [6:0]       o_stage3_gain_code,
    output logic             o_stage3_offset_neg,
    output logic [5:0]       o_stage3_offset_mag,
    output logic             o_irq
);
    typedef enum logic [2:0] {S_IDLE, S_PRE, S_INTEG, S_QUANT, S_POST} st_t;

    // =============================================================
    // apb decode
    logic wr_en;
    logic rd_en;
    logic hit;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign pready  = 1'b1;
    assign hit     = (paddr == `IASQ_OFF_CTRL) || (paddr == `IASQ_OFF_CFG) ||
                     (paddr == `IASQ_OFF_GAIN) || (paddr == `IASQ_OFF_STATUS) ||
                     (paddr == `IASQ_OFF_RESULT) || (paddr == `IASQ_OFF_IRQ_STAT) ||
                     (paddr == `IASQ_OFF_IRQ_MASK);
    assign pslverr = psel && penable && !hit;

    logic start_wr;
    logic def_wr;
    assign start_wr = wr_en && paddr == `IASQ_OFF_CTRL && pwdata[`IASQ_CTRL_START];
    assign def_wr   = wr_en && paddr == `IASQ_OFF_CTRL && pwdata[`IASQ_CTRL_DEFAULTS];

    // =============================================================
    // configuration registers
    iasq_pkg::iasq_cfg_t    cfg_q;
    logic [6:0]             gain_q;
    iasq_pkg::iasq_offset_t offs_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || def_wr) begin
            cfg_q.cont     <= 1'b0;
            cfg_q.ref_mode <= iasq_pkg::iasq_ref_mode_t'(`IASQ_DEF_REF);
            cfg_q.nel_sel  <= `IASQ_DEF_NEL;
            cfg_q.osr_sel  <= `IASQ_DEF_OSR;
            cfg_q.fs_sel   <= `IASQ_DEF_FS;
            gain_q         <= `IASQ_DEF_GAIN;
            offs_q         <= `IASQ_DEF_OFFS;
        end else if (wr_en && paddr == `IASQ_OFF_CFG) begin
            cfg_q <= pwdata[`IASQ_CFG_CONT:`IASQ_CFG_FS_LSB];
        end else if (wr_en && paddr == `IASQ_OFF_GAIN) begin
            gain_q <= pwdata[`IASQ_GAIN_G_LSB +: 7];
            offs_q <= pwdata[`IASQ_GAIN_O_LSB +: 7];
        end
    end

    // gain and offset codes go straight to the analog stage
    assign o_stage3_gain_code  = gain_q;
    assign o_stage3_offset_neg = offs_q.neg;
    assign o_stage3_offset_mag = offs_q.mag;

    // =============================================================
    // sampling tick
    logic tick;
    logic restart;
    iasq_tick_gen u_tick (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_restart (restart),
        .i_fs_sel  (cfg_q.fs_sel),
        .o_tick    (tick)
    );

    // =============================================================
    // sequencer state
    st_t         st_q;
    logic [10:0] per_q;     // periods within an elementary conversion
    logic [2:0]  el_q;      // elementary index
    logic [3:0]  set_q;     // settle counter
    logic [14:0] acc_q;     // ones count of one elementary conversion
    logic [18:0] sum_q;     // signed sum of elementary results
    logic [15:0] result_q;
    logic        busy_q;
    logic [1:0]  ref_cnt_q;
    logic [10:0] oversampling_ratio;
    logic [3:0]  nel;
    logic        el_last;
    logic        per_last;
    logic [18:0] el_val;
    logic [18:0] sum_nx;
    logic [18:0] mean;
    logic        done;

    // ratio and count latched at start so a cfg write mid-conversion cannot change them; rate, ref mode and cont are not latched
    logic [2:0]  osr_lat_q;
    logic [1:0]  nel_lat_q;
    assign oversampling_ratio     = 11'(11'h008 << osr_lat_q);
    assign nel     = 4'(4'h1 << nel_lat_q);
    assign per_last = (per_q == oversampling_ratio);
    assign el_last  = ({1'b0, el_q} == nel - 4'h1);
    assign restart  = start_wr || def_wr;
    // bipolar result: 2*ones - osr, sign flipped on odd conversions
    assign el_val   = el_q[0] ? (19'(oversampling_ratio) - 19'({acc_q, 1'b0}))
                              : (19'({acc_q, 1'b0}) - 19'(oversampling_ratio));
    assign sum_nx   = sum_q + el_val;
    assign mean     = $signed(sum_q) >>> nel_lat_q;
    assign done     = st_q == S_POST && set_q == 4'h0;

    // main sequencer; restart abandons whatever was running
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_q      <= S_IDLE;
            per_q     <= 11'h000;
            el_q      <= 3'h0;
            set_q     <= 4'h0;
            acc_q     <= 15'h0000;
            sum_q     <= 19'h00000;
            busy_q    <= 1'b0;
            osr_lat_q <= 3'h0;
            nel_lat_q <= 2'h0;
        end else if (restart) begin
            st_q      <= S_PRE;
            set_q     <= `IASQ_SETTLE_CYC;
            per_q     <= 11'h000;
            el_q      <= 3'h0;
            acc_q     <= 15'h0000;
            sum_q     <= 19'h00000;
            busy_q    <= 1'b1;
            osr_lat_q <= def_wr ? `IASQ_DEF_OSR : cfg_q.osr_sel;
            nel_lat_q <= def_wr ? `IASQ_DEF_NEL : cfg_q.nel_sel;
        end else begin
            case (st_q)
                S_IDLE: begin
                    busy_q <= 1'b0;
                end
                S_PRE: begin
                    if (set_q != 4'h0) begin
                        set_q <= set_q - 4'h1;
                    end else if (tick) begin
                        st_q <= S_INTEG;
                    end
                end
                S_INTEG: begin
                    if (tick) begin
                        if (per_last) begin
                            per_q <= 11'h000;
                            acc_q <= 15'h0000;
                            sum_q <= sum_nx;
                            el_q  <= el_q + 3'h1;
                            if (el_last) begin
                                st_q <= S_QUANT;
                            end
                        end else begin
                            per_q <= per_q + 11'h001;
                            acc_q <= acc_q + 15'(i_mod_bit);
                        end
                    end
                end
                S_QUANT: begin
                    if (tick) begin
                        st_q  <= S_POST;
                        set_q <= `IASQ_SETTLE_CYC;
                    end
                end
                S_POST: begin
                    if (set_q != 4'h0) begin
                        set_q <= set_q - 4'h1;
                    end else if (cfg_q.cont) begin
                        st_q   <= S_PRE;
                        set_q  <= `IASQ_SETTLE_CYC;
                        el_q   <= 3'h0;
                        sum_q  <= 19'h00000;
                    end else begin
                        st_q   <= S_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // result saturated to 16 bits, same edge that drops busy when cont is clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            result_q <= 16'h0000;
        end else if (done && !restart) begin
            if ($signed(mean) > $signed(19'h07fff)) begin
                result_q <= 16'h7fff;
            end else if ($signed(mean) < $signed(19'h78000)) begin
                result_q <= 16'h8000;
            end else begin
                result_q <= mean[15:0];
            end
        end
    end

    // =============================================================
    // reference state: held high or low, or toggled per elementary conversion or at half rate
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || restart) begin
            ref_cnt_q <= 2'h0;
        end else if (st_q == S_INTEG && tick && per_last) begin
            ref_cnt_q <= ref_cnt_q + 2'h1;
        end
    end

    always_comb begin
        case (cfg_q.ref_mode)
            iasq_pkg::IASQ_REF_HIGH:   o_ref_state = 1'b1;
            iasq_pkg::IASQ_REF_LOW:    o_ref_state = 1'b0;
            iasq_pkg::IASQ_REF_TOGGLE: o_ref_state = ref_cnt_q[0];
            default:                   o_ref_state = ref_cnt_q[1];
        endcase
    end

    // analog strobes
    assign o_integrate     = (st_q == S_INTEG);
    assign o_mod_reset     = (st_q == S_PRE) || (st_q == S_INTEG && per_q == 11'h000);
    assign o_offset_invert = el_q[0];
    assign o_quantize      = (st_q == S_QUANT);

    // =============================================================
    // interrupt: bit0 conversion done; write one to clear, set wins
    logic irq_st_q;
    logic irq_mk_q;
    logic irq_clr;
    assign irq_clr = wr_en && paddr == `IASQ_OFF_IRQ_STAT && pwdata[0];
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            irq_st_q <= 1'b0;
            irq_mk_q <= 1'b0;
        end else begin
            irq_st_q <= (done && !restart) || (irq_st_q && !irq_clr);
            if (wr_en && paddr == `IASQ_OFF_IRQ_MASK) begin
                irq_mk_q <= pwdata[0];
            end
        end
    end
    assign o_irq = irq_st_q && irq_mk_q;

    // =============================================================
    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en && paddr == `IASQ_OFF_CFG) begin
            prdata[`IASQ_CFG_CONT:0] = cfg_q;
        end else if (rd_en && paddr == `IASQ_OFF_GAIN) begin
            prdata[14:0] = {offs_q, 1'b0, gain_q};
        end else if (rd_en && paddr == `IASQ_OFF_STATUS) begin
            prdata[0] = busy_q;
        end else if (rd_en && paddr == `IASQ_OFF_RESULT) begin
            prdata[15:0] = result_q;
        end else if (rd_en && paddr == `IASQ_OFF_IRQ_STAT) begin
            prdata[0] = irq_st_q;
        end else if (rd_en && paddr == `IASQ_OFF_IRQ_MASK) begin
            prdata[0] = irq_mk_q;
        end
    end

    // =============================================================
    // checks
    a_restart_busy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        restart |=> busy_q && st_q == S_PRE) else $error("busy not set on start");
    a_done_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        done && !restart && !cfg_q.cont |=> !busy_q) else $error("busy stuck");
    a_per_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        st_q == S_INTEG |-> per_q <= oversampling_ratio) else $error("period overrun");
    a_el_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        st_q == S_INTEG |-> {1'b0, el_q} < nel) else $error("count overrun");
    a_def_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        def_wr |=> gain_q == `IASQ_DEF_GAIN && cfg_q.osr_sel == `IASQ_DEF_OSR)
        else $error("defaults not loaded");
    a_quant_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        st_q == S_QUANT && tick && !restart |=> st_q == S_POST) else $error("quant stuck");
    a_ref_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cfg_q.ref_mode == iasq_pkg::IASQ_REF_HIGH |-> o_ref_state) else $error("ref not high");
    a_pre_settle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        restart |=> !o_integrate [*4]) else $error("no start settle");
    a_irq_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        done && !restart |=> irq_st_q) else $error("done flag not set");

endmodule // iasq_seq
`default_nettype wire

//--- iasq_tick_gen.sv
// oversampling tick divider from the system clock
`timescale 1ns/10ps
`default_nettype none
`include "iasq_map.svh"

module iasq_tick_gen (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_restart,
    input  wire logic [1:0] i_fs_sel,
    output logic            o_tick
);
    // =============================================================
    // divider: 500 kHz base period times 2^(3-sel)
    localparam int unsigned BASE = `IASQ_DIV_500K;
    logic [11:0] cnt_q;
    logic [11:0] lim;

    assign lim = 12'((BASE << (2'd3 - i_fs_sel)) - 1);

    // restart aligns the first tick to the conversion start
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_restart || cnt_q >= lim) begin
            cnt_q <= 12'h000;
        end else begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    assign o_tick = (cnt_q == lim);

endmodule // iasq_tick_gen
`default_nettype wire

//--- incremental_adc_sequencer_tb.sv
// self-checking bench for the adc sequencer: registers, timing, result, irq
`timescale 1ns/10ps
`default_nettype none
`include "iasq_map.svh"

module incremental_adc_sequencer_tb;
    logic        i_ref_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, level;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        er, mod_bit, integ, mreset, inv, ref_st, quant, oneg, irq;
    logic [6:0]  gain, g, o;
    logic [5:0]  omag;
    int          num_errors, tests_run, seed;

    // =============================================================
    // design, its modulator partner and the clock
    iasq_seq DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_mod_bit(mod_bit), .o_integrate(integ), .o_mod_reset(mreset),
        .o_offset_invert(inv), .o_ref_state(ref_st), .o_quantize(quant),
        .o_stage3_gain_code(gain), .o_stage3_offset_neg(oneg), .o_stage3_offset_mag(omag),
        .o_irq(irq));
    iasq_mod_model PARTNER (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_integrate(integ),
        .i_mod_reset(mreset), .i_quantize(quant), .i_level(level), .o_mod_bit(mod_bit));

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // =============================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge so callers see the registers after the write
        @(posedge i_ref_clk);
    endtask

    task automatic do_reset();
        i_rst_n <= 1'b0;
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
    endtask

    // sampling periods of one conversion after the start wait: integrate and quantize
    function automatic int exp_ticks(input int oversampling_ratio, input int nel);
        return (1 << nel) * ((1 << (3 + oversampling_ratio)) + 1) + 1;
    endfunction

    // start a conversion and measure it from the ports
    task automatic run_conv(input logic [1:0] fs, input logic [2:0] oversampling_ratio, input logic [1:0] nel,
                            input logic [1:0] rm);
        int cyc, qc, ic, mc, flips, rflips, refbad, per, tk, el;
        logic prev, rprev;
        per = 200 << (3 - fs);
        tk  = exp_ticks(oversampling_ratio, nel);
        el  = 1 << nel;
        level <= 1'($random(seed));
        apb(1'b1, `IASQ_OFF_CFG, {23'h0, rm, nel, oversampling_ratio, fs});
        apb(1'b1, `IASQ_OFF_CTRL, 32'h1);
        cyc = 0;
        qc = 0;
        ic = 0;
        mc = 0;
        flips = 0;
        rflips = 0;
        refbad = 0;
        prev = inv;
        rprev = ref_st;
        // slowest rate with two elementary runs needs about 32000 cycles
        while (irq !== 1'b1 && cyc < 33000) begin
            @(posedge i_ref_clk);
            cyc++;
            qc += (quant === 1'b1);
            ic += (integ === 1'b1);
            mc += (mreset === 1'b1);
            flips += (inv !== prev);
            rflips += (ref_st !== rprev);
            prev = inv;
            rprev = ref_st;
            refbad += (rm < 2 && ref_st !== ~rm[0]);
        end
        check("conv len ok", 1, cyc >= tk * per && cyc <= tk * per + per + 40);
        check("quant len ok", 1, qc >= per - 2 && qc <= per + 2);
        check("integ len ok", 1, ic >= (tk - 1) * per - 2 && ic <= (tk - 1) * per + 2);
        check("reset len ok", 1, mc >= (el + 1) * per - 3 && mc <= (el + 1) * per + 2);
        check("flips ok", 1, flips + 1 >= el && flips <= el + 1);
        check("ref forced", 0, refbad);
        check("ref flips", (rm == 2) ? el : (rm == 3) ? el / 2 : 0, rflips);
        apb(1'b0, `IASQ_OFF_STATUS, 32'h0);
        check("busy end", 32'h0, rd);
        apb(1'b0, `IASQ_OFF_RESULT, 32'h0);
        if (nel != 0) check("mean result", 32'h0, rd);
        apb(1'b1, `IASQ_OFF_IRQ_MASK, 32'h0);
        check("irq masked", 1'b0, irq);
        apb(1'b1, `IASQ_OFF_IRQ_MASK, 32'h1);
        check("irq unmasked", 1'b1, irq);
        apb(1'b1, `IASQ_OFF_IRQ_STAT, 32'h1);
        check("irq cleared", 1'b0, irq);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // =============================================================
    // watchdog: the seven conversions take about 85500 cycles in all
    initial begin
        #950000;
        num_errors++;
        summarize();
    end

    // =============================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, level, i_rst_n} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        num_errors = 0;
        tests_run = 0;
        seed = 25870;
        do_reset();
        check("gain rst", 7'h0c, gain);
        check("offs rst", {1'b1, 6'h00}, {oneg, omag});
        apb(1'b0, `IASQ_OFF_CFG, 32'h0);
        check("cfg rst", 32'h128, rd);
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped err", 1'b1, er);
        // gain and offset codes: corners first, then random
        for (int i = 0; i < 6; i++) begin
            g = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
            o = (i == 0) ? 7'h40 : (i == 1) ? 7'h3f : 7'($random(seed));
            apb(1'b1, `IASQ_OFF_GAIN, {17'h0, o, 1'b0, g});
            check("gain code", g, gain);
            check("offset code", o, {oneg, omag});
        end
        // restart a running conversion with restore defaults
        apb(1'b1, `IASQ_OFF_CFG, 32'h00f);
        apb(1'b1, `IASQ_OFF_CTRL, 32'h1);
        repeat (300) @(posedge i_ref_clk);
        apb(1'b0, `IASQ_OFF_STATUS, 32'h0);
        check("busy running", 32'h1, rd);
        apb(1'b1, `IASQ_OFF_CTRL, 32'h2);
        apb(1'b0, `IASQ_OFF_STATUS, 32'h0);
        check("busy after def", 32'h1, rd);
        apb(1'b0, `IASQ_OFF_CFG, 32'h0);
        check("cfg def", 32'h128, rd);
        check("gain def", 7'h0c, gain);
        do_reset();
        apb(1'b1, `IASQ_OFF_IRQ_MASK, 32'h1);
        // every count select at the fast rate, then the slower rates
        for (int i = 0; i < 7; i++) begin
            run_conv((i < 4) ? 2'd3 : 2'(i - 4), 3'h0, (i < 4) ? 2'(i) : 2'd1, 2'(i));
        end
        summarize();
    end
endmodule // incremental_adc_sequencer_tb

`default_nettype wire
